// ### sepc_front.sv
// Serial EEPROM front end: link decoder, write latch, status and protection
`timescale 1ns/1ps
module sepc_front
  import sepc_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int unsigned WC_CYCLES = WC_CYCLES_DFLT
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_o,
  output logic so_oe,
  // Array write side
  output logic array_wr_req,
  output logic [ADDR_W-1:0] array_wr_addr,
  output logic [7:0] array_wr_data,
  // Array read side
  output logic [ADDR_W-1:0] array_rd_addr,
  input wire logic [7:0] array_rd_data,
  // Status view
  output logic [7:0] status_view
);

  localparam int TMR_W = $clog2(WC_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WC_CYCLES);
  localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

  // ==========================================================================
  // Link domain declarations
  logic link_rst_n;
  sepc_link_e lstate;
  sepc_link_e next_lstate;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [7:0] sh;
  logic [7:0] sh_next;
  logic [7:0] opc_in;
  logic [7:0] opc_l;
  logic [7:0] next_opc;
  logic [15:0] addr_l;
  logic [15:0] next_addr;
  logic evt_fire;
  sepc_kind_e evt_kind;
  sepc_kind_e cap_kind;
  logic [15:0] cap_addr;
  logic [7:0] cap_data;
  logic evt_tgl;
  logic [7:0] st_s1;
  logic [7:0] st_s2;
  logic busy_l;
  logic op_sr;
  logic op_stwr;
  logic op_ard;
  logic op_awr;
  logic in_sr;
  logic in_known;
  logic run;
  logic drive_now;
  logic [7:0] out_byte;
  logic [2:0] out_idx;
  logic so_q;
  logic drv_q;

  // ==========================================================================
  // System domain declarations
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic wp_s1;
  logic wp_s2;
  logic tg_s1;
  logic tg_s2;
  logic tg_s3;
  logic new_evt;
  logic cs_rise;
  sepc_core_e cstate;
  sepc_core_e next_cstate;
  sepc_kind_e pend_kind;
  logic [15:0] pend_addr;
  logic [7:0] pend_data;
  logic wel;
  logic next_wel;
  logic honour;
  logic next_honour;
  logic [1:0] guard;
  logic [1:0] next_guard;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic hw_prot;
  logic addr_guarded;
  logic wr_start;
  logic wr_done;
  logic st_abort;
  logic [7:0] next_status;
  logic [ADDR_W-1:0] pend_a;

  // ==========================================================================
  // Link reset: select high clears the transaction state
  assign link_rst_n = rst_n & ~cs_n;

  // ==========================================================================
  // Link decode
  assign sh_next = {sh[6:0], si};
  assign opc_in = sh_next & OPC_MASK;
  assign run = hold_n;
  assign busy_l = st_s2[ST_BUSY];
  assign op_sr = (opc_l == OPC_STATUS_READ);
  assign op_stwr = (opc_l == OPC_STATUS_WRITE);
  assign op_ard = (opc_l == OPC_ARRAY_READ);
  assign op_awr = (opc_l == OPC_ARRAY_WRITE);
  assign in_sr = (opc_in == OPC_STATUS_READ);
  assign in_known = in_sr
    || (opc_in == OPC_STATUS_WRITE)
    || (opc_in == OPC_ARRAY_READ)
    || (opc_in == OPC_ARRAY_WRITE);

  always_comb begin
    next_lstate = lstate;
    next_cnt = cnt + 6'h01;
    next_opc = opc_l;
    next_addr = addr_l;
    evt_fire = 1'b0;
    evt_kind = KIND_NONE;
    case (lstate)
      LINK_OPC: begin
        if (cnt == OPC_LAST) begin
          next_opc = opc_in;
          if (busy_l && !in_sr) begin
            next_lstate = LINK_STOP;
          end else if (opc_in == OPC_LATCH_SET) begin
            evt_fire = 1'b1;
            evt_kind = KIND_SET;
            next_lstate = LINK_STOP;
          end else if (opc_in == OPC_LATCH_CLEAR) begin
            evt_fire = 1'b1;
            evt_kind = KIND_CLR;
            next_lstate = LINK_STOP;
          end else if (in_known) begin
            next_lstate = LINK_BODY;
          end else begin
            next_lstate = LINK_STOP;
          end
        end
      end
      LINK_BODY: begin
        if (op_stwr && cnt == STWR_LAST) begin
          evt_fire = 1'b1;
          evt_kind = KIND_STWR;
          next_lstate = LINK_STOP;
        end
        if ((op_ard || op_awr) && cnt == ADDR_HI_LAST) begin
          next_addr = {sh_next, addr_l[7:0]};
        end
        if ((op_ard || op_awr) && cnt == ADDR_LO_LAST) begin
          next_addr = {addr_l[15:8], sh_next};
        end
        if (op_awr && cnt == AWR_LAST) begin
          evt_fire = 1'b1;
          evt_kind = KIND_ARWR;
          next_lstate = LINK_STOP;
        end
        if (op_ard && cnt == AWR_LAST) begin
          next_cnt = RD_DATA_FIRST;
          next_addr = addr_l + 16'h0001;
        end
      end
      LINK_STOP: begin
        next_cnt = cnt;
      end
      default: begin
        next_lstate = LINK_STOP;
      end
    endcase
  end

  // ==========================================================================
  // Link state, sampled on the master's rising clock edge
  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lstate <= LINK_OPC;
      cnt <= 6'h00;
      sh <= 8'h00;
      opc_l <= 8'h00;
      addr_l <= 16'h0000;
    end else if (run && lstate != LINK_STOP) begin
      lstate <= next_lstate;
      cnt <= next_cnt;
      sh <= sh_next;
      opc_l <= next_opc;
      addr_l <= next_addr;
    end
  end

  // Event payload survives select going high
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      cap_kind <= KIND_NONE;
      cap_addr <= 16'h0000;
      cap_data <= 8'h00;
      evt_tgl <= 1'b0;
    end else if (run && evt_fire && !cs_n) begin
      cap_kind <= evt_kind;
      cap_addr <= addr_l;
      cap_data <= sh_next;
      evt_tgl <= ~evt_tgl;
    end
  end

  // Status byte carried into the link domain
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      st_s1 <= 8'h00;
      st_s2 <= 8'h00;
    end else begin
      st_s1 <= status_view;
      st_s2 <= st_s1;
    end
  end

  // ==========================================================================
  // Serial output, launched on the falling clock edge
  assign out_byte = op_sr ? st_s2 : array_rd_data;
  assign out_idx = 3'h7 - cnt[2:0];
  assign drive_now = (lstate == LINK_BODY)
    && (op_sr || (op_ard && cnt >= RD_DATA_FIRST));

  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_q <= 1'b0;
      drv_q <= 1'b0;
    end else if (run) begin
      so_q <= out_byte[out_idx];
      drv_q <= drive_now;
    end
  end

  assign so_o = so_q;
  assign so_oe = drv_q & hold_n & ~cs_n;
  assign array_rd_addr = addr_l[ADDR_W-1:0];

  // ==========================================================================
  // System domain synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
      tg_s1 <= evt_tgl;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end

  assign new_evt = tg_s2 ^ tg_s3;
  assign cs_rise = cs_s2 & ~cs_s3;

  // ==========================================================================
  // Protection decode
  assign hw_prot = honour & ~wp_s2;
  assign pend_a = pend_addr[ADDR_W-1:0];
  assign addr_guarded = (guard == 2'h3)
    || (guard == 2'h2 && pend_a[ADDR_W-1])
    || (guard == 2'h1 && pend_a[ADDR_W-1:ADDR_W-2] == 2'h3);
  assign st_abort = (pend_kind == KIND_STWR) && hw_prot;

  // ==========================================================================
  // Command execution
  always_comb begin
    next_cstate = cstate;
    next_wel = wel;
    next_honour = honour;
    next_guard = guard;
    next_tmr = tmr;
    wr_start = 1'b0;
    wr_done = 1'b0;
    case (cstate)
      CORE_IDLE: begin
        if (new_evt) begin
          next_cstate = CORE_ARMED;
        end
      end
      CORE_ARMED: begin
        if (st_abort) begin
          next_cstate = CORE_IDLE;
        end else if (cs_rise) begin
          next_cstate = CORE_IDLE;
          case (pend_kind)
            KIND_SET: begin
              next_wel = 1'b1;
            end
            KIND_CLR: begin
              next_wel = 1'b0;
            end
            KIND_STWR: begin
              if (wel) begin
                next_cstate = CORE_BUSY;
                next_tmr = TMR_LOAD;
              end
            end
            KIND_ARWR: begin
              if (wel && !addr_guarded) begin
                next_cstate = CORE_BUSY;
                next_tmr = TMR_LOAD;
                wr_start = 1'b1;
              end
            end
            default: begin
              next_cstate = CORE_IDLE;
            end
          endcase
        end
      end
      CORE_BUSY: begin
        next_tmr = tmr - TMR_ONE;
        if (tmr <= TMR_ONE) begin
          wr_done = 1'b1;
          next_cstate = CORE_IDLE;
          next_wel = 1'b0;
          if (pend_kind == KIND_STWR) begin
            next_honour = pend_data[ST_HONOUR];
            next_guard = {pend_data[ST_GUARD_HI], pend_data[ST_GUARD_LO]};
          end
        end
      end
      default: begin
        next_cstate = CORE_IDLE;
      end
    endcase
  end

  // Status word: all ones while writing, else live bits
  assign next_status = (next_cstate == CORE_BUSY) ? ST_ALL_ONES :
    {next_honour, 3'h0, next_guard, next_wel, 1'b0};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cstate <= CORE_IDLE;
      wel <= RST_WEL;
      honour <= RST_HONOUR;
      guard <= RST_GUARD;
      tmr <= '0;
      status_view <= {RST_HONOUR, 3'h0, RST_GUARD, RST_WEL, 1'b0};
    end else begin
      cstate <= next_cstate;
      wel <= next_wel;
      honour <= next_honour;
      guard <= next_guard;
      tmr <= next_tmr;
      status_view <= next_status;
    end
  end

  // Pending command copy, taken once the event is seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_kind <= KIND_NONE;
      pend_addr <= 16'h0000;
      pend_data <= 8'h00;
    end else if (new_evt && cstate == CORE_IDLE) begin
      pend_kind <= cap_kind;
      pend_addr <= cap_addr;
      pend_data <= cap_data;
    end
  end

  // ==========================================================================
  // Array write request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      array_wr_req <= 1'b0;
      array_wr_addr <= '0;
      array_wr_data <= 8'h00;
    end else begin
      array_wr_req <= wr_start;
      if (wr_start) begin
        array_wr_addr <= pend_a;
        array_wr_data <= pend_data;
      end
    end
  end

endmodule

// ### sepc_front_properties.sv
// Concurrent checks on the ports of the serial EEPROM front end
`timescale 1ns/1ps
module sepc_front_properties
  import sepc_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int unsigned WC_CYCLES = WC_CYCLES_DFLT
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_o,
  input wire logic so_oe,
  // Array side
  input wire logic array_wr_req,
  input wire logic [ADDR_W-1:0] array_wr_addr,
  input wire logic [7:0] array_wr_data,
  input wire logic [ADDR_W-1:0] array_rd_addr,
  input wire logic [7:0] array_rd_data,
  // Status view
  input wire logic [7:0] status_view
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Helper logic
  int unsigned busy_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_cnt <= 0;
    else if (status_view[ST_BUSY]) busy_cnt <= busy_cnt + 1;
    else busy_cnt <= 0;
  end

  function automatic logic guard_ok(logic [1:0] lvl, logic [ADDR_W-1:0] a);
    return (lvl == 2'h0) || (lvl == 2'h1 && a[ADDR_W-1 -: 2] != 2'h3) ||
      (lvl == 2'h2 && !a[ADDR_W-1]);
  endfunction

  // ==========================================================================
  // Properties
  property p_cs_quiet;
    cs_n |-> !so_oe;
  endproperty
  a_cs_quiet: assert property (p_cs_quiet)
    else $error("serial output enabled while deselected");
  property p_hold_quiet;
    !hold_n |-> !so_oe;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet)
    else $error("serial output enabled while paused");
  property p_busy_ones;
    status_view[ST_BUSY] |-> status_view == ST_ALL_ONES;
  endproperty
  a_busy_ones: assert property (p_busy_ones)
    else $error("status not all ones while busy");
  property p_idle_zero;
    !status_view[ST_BUSY] |-> status_view[6:4] == 3'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("status bits 6 to 4 not zero while ready");
  property p_busy_len;
    $fell(status_view[ST_BUSY]) |->
      busy_cnt >= WC_CYCLES - 1 && busy_cnt <= WC_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  property p_wel_drop;
    $fell(status_view[ST_BUSY]) |-> !status_view[ST_WEL];
  endproperty
  a_wel_drop: assert property (p_wel_drop)
    else $error("write latch still set after write cycle");
  property p_nv_hold;
    !status_view[ST_BUSY] && !$past(status_view[ST_BUSY]) |->
      $stable({status_view[ST_HONOUR], status_view[ST_GUARD_HI:ST_GUARD_LO]});
  endproperty
  a_nv_hold: assert property (p_nv_hold)
    else $error("protection bits changed without write cycle");
  property p_wr_enabled;
    array_wr_req |-> $past(status_view[ST_WEL]) && !$past(status_view[ST_BUSY]);
  endproperty
  a_wr_enabled: assert property (p_wr_enabled)
    else $error("array write without latch or while busy");
  property p_guard;
    array_wr_req |->
      guard_ok($past(status_view[ST_GUARD_HI:ST_GUARD_LO]), array_wr_addr);
  endproperty
  a_guard: assert property (p_guard)
    else $error("array write into guarded region");
  property p_reset_sv;
    $rose(rst_n) |-> status_view == 8'h00 && !so_oe;
  endproperty
  a_reset_sv: assert property (p_reset_sv)
    else $error("status not cleared after reset");

  // ==========================================================================
  // Coverage
  c_read: cover property ($rose(so_oe));
  c_awr: cover property (array_wr_req);
  c_wc: cover property ($fell(status_view[ST_BUSY]));
endmodule

bind sepc_front sepc_front_properties #(.ADDR_W(ADDR_W),
  .WC_CYCLES(WC_CYCLES)) u_props (.clk(clk), .rst_n(rst_n), .sck(sck),
  .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o),
  .so_oe(so_oe), .array_wr_req(array_wr_req), .array_wr_addr(array_wr_addr),
  .array_wr_data(array_wr_data), .array_rd_addr(array_rd_addr),
  .array_rd_data(array_rd_data), .status_view(status_view));

// ### sepc_master_model.sv
// Serial link master model in mode 0 with pause support
`timescale 1ns/1ps
module sepc_master_model (
  // Link pins
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so_o,
  input wire logic so_oe
);
  localparam realtime HALF = 24.0;
  logic hold_oe;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    hold_oe = 1'b0;
  end

  // ==========================================================================
  // Frame end, link released
  task automatic done_frame();
    cs_n = 1'b1;
    si = ~si;
    #200;
  endtask

  // ==========================================================================
  // One frame of n bits, optional pause before bit hold_at
  task automatic xfer(input logic [31:0] tx, input int n, input int hold_at,
      input bit stay, output logic [31:0] rx, output logic oe_seen);
    rx = '0;
    oe_seen = 1'b0;
    #7 cs_n = 1'b0;
    #HALF;
    for (int i = n - 1; i >= 0; i--) begin
      if (i == hold_at) begin
        #(HALF / 2) hold_n = 1'b0;
        repeat (2) begin
          si = ~si;
          #HALF sck = 1'b1;
          hold_oe = hold_oe | so_oe;
          #HALF sck = 1'b0;
        end
        #(HALF / 2) hold_n = 1'b1;
        #(HALF / 2);
      end
      si = tx[i];
      #HALF sck = 1'b1;
      rx = {rx[30:0], so_o};
      oe_seen = oe_seen | so_oe;
      #HALF sck = 1'b0;
    end
    #HALF;
    if (!stay) done_frame();
  endtask
endmodule

// ### sepc_pkg.sv
// Constants and types for the serial EEPROM command and protection front end
// ==========================================================================
// Contract
// - Device is always a serial slave; the serial clock is input only.
// - All serial bit groups travel most significant bit first.
// - First byte after select falls is the operation code.
// - Unknown operation code: shift nothing more, output off until reselect.
// - Select high: serial input ignored, serial output high impedance.
// - Paused: keep transaction state, output off, ignore input and clock.
// - Protect pin low with honour bit set refuses all status writes.
// - Protect pin falling under select aborts status write; not once begun.
// - Honour bit zero: protect pin ignored, status writes allowed.
// - Eight-bit instruction register; transaction starts on select fall.
// - Decode latch set 0000X110, latch clear 0000X100, status read 0000X101.
// - Decode status write 0000X001, array read 0000X011, array write 0000X010.
// - Write-enable latch clears at power-up; master must set it first.
// - Latch clear disables programming regardless of the protect pin.
// - Status bit 1 shows the latch; latch clear refuses all writes.
// - Status bit 0 is zero when ready, one while writing.
// - Bits 6-4 read zero when idle; whole byte reads ones while writing.
// - Guard levels protect none, top quarter, top half, whole array.
// - Guard and honour bits are nonvolatile: need latch and write cycle.
// - Hardware protection blocks status and guarded array writes only.
// - Honour bit cannot be cleared while protect pin stays low.
// - Latch clears automatically when an internal write cycle completes.
// - During a write cycle only status read is accepted.
package sepc_pkg;

  // ==========================================================================
  // Operation codes
  localparam logic [7:0] OPC_MASK = 8'hF7;
  localparam logic [7:0] OPC_LATCH_SET = 8'h06;
  localparam logic [7:0] OPC_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_ARRAY_READ = 8'h03;
  localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;

  // ==========================================================================
  // Status byte layout and values
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_GUARD_LO = 2;
  localparam int ST_GUARD_HI = 3;
  localparam int ST_HONOUR = 7;
  localparam logic [7:0] ST_ALL_ONES = 8'hFF;
  localparam logic [1:0] RST_GUARD = 2'h0;
  localparam logic RST_HONOUR = 1'h0;
  localparam logic RST_WEL = 1'h0;

  // ==========================================================================
  // Bit counts on the link (index of the last bit of each field, of the first bit for read data)
  localparam logic [5:0] OPC_LAST = 6'h07;
  localparam logic [5:0] ADDR_HI_LAST = 6'h0F;
  localparam logic [5:0] STWR_LAST = 6'h0F;
  localparam logic [5:0] ADDR_LO_LAST = 6'h17;
  localparam logic [5:0] RD_DATA_FIRST = 6'h18;
  localparam logic [5:0] AWR_LAST = 6'h1F;

  // ==========================================================================
  // Write cycle timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned T_WC_MS = 5;
  localparam int unsigned WC_CYCLES_DFLT = T_WC_MS * 1000 * CLK_MHZ;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    LINK_OPC = 2'h0,
    LINK_BODY = 2'h1,
    LINK_STOP = 2'h3
  } sepc_link_e;

  typedef enum logic [1:0] {
    CORE_IDLE = 2'h0,
    CORE_ARMED = 2'h1,
    CORE_BUSY = 2'h3
  } sepc_core_e;

  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_SET = 3'h1,
    KIND_CLR = 3'h3,
    KIND_STWR = 3'h2,
    KIND_ARWR = 3'h6
  } sepc_kind_e;

endpackage

// ### test_sepc_front.sv
// Self-checking bench for the serial EEPROM front end
`timescale 1ns/1ps
module test_sepc_front;
  import sepc_pkg::*;
  localparam int WC = 100;
  logic clk, rst_n, wp_n, sck, cs_n, si, hold_n, so_o, so_oe, array_wr_req;
  logic [9:0] array_wr_addr, array_rd_addr, wr_addr_seen;
  logic [7:0] array_wr_data, array_rd_data, status_view, wr_data_seen;
  logic [31:0] rx;
  logic oe;
  int mismatches = 0;
  int num_checks = 0;
  int wr_cnt = 0;
  int cycles = 0;

  assign array_rd_data = array_rd_addr[7:0] ^ 8'hA5;

  sepc_front #(.ADDR_W(10), .WC_CYCLES(WC)) dut (.clk(clk), .rst_n(rst_n),
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so_o(so_o), .so_oe(so_oe), .array_wr_req(array_wr_req),
    .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data),
    .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data),
    .status_view(status_view));
  sepc_master_model m (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .so_o(so_o), .so_oe(so_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // Array write monitor and timeout
  always @(posedge clk) begin
    cycles++;
    if (array_wr_req === 1'b1) begin
      wr_cnt++;
      wr_addr_seen = array_wr_addr;
      wr_data_seen = array_wr_data;
    end
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmd(logic [7:0] o);
    m.xfer({24'h0, o}, 8, -1, 1'b0, rx, oe);
  endtask
  task automatic wstat(logic [7:0] d, bit stay);
    m.xfer({16'h0, OPC_STATUS_WRITE, d}, 16, -1, stay, rx, oe);
  endtask
  task automatic awrite(logic [9:0] a, logic [7:0] d);
    m.xfer({OPC_ARRAY_WRITE, 6'h00, a, d}, 32, -1, 1'b0, rx, oe);
  endtask
  task automatic rd_status(logic [7:0] exp);
    m.xfer({16'h0, OPC_STATUS_READ, 8'h00}, 16, -1, 1'b0, rx, oe);
    chk("status_link", 16'(exp), 16'(rx[7:0]));
    chk("status_oe", 16'h0001, 16'(oe));
    chk("status_view", 16'(exp), 16'(status_view));
  endtask
  task automatic set_wp(logic v);
    @(posedge clk) wp_n <= v;
    repeat (3) @(posedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk("status_view", 16'h0000, 16'(status_view));
    rd_status(8'h00);
    awrite(10'h010, 8'h11);
    chk("wr_cnt", 16'h0000, 16'(wr_cnt));
    $display("test reset done");
  endtask
  task automatic t_latch();
    cmd(8'h0E);
    rd_status(8'h02);
    set_wp(1'b0);
    cmd(8'h0C);
    rd_status(8'h00);
    $display("test latch done");
  endtask
  task automatic t_status_write();
    cmd(OPC_LATCH_SET);
    wstat(8'hFD, 1'b0);
    rd_status(8'hFF);
    cmd(OPC_LATCH_SET);
    repeat (WC) @(posedge clk);
    rd_status(8'h8C);
    $display("test status write done");
  endtask
  task automatic t_protect();
    cmd(OPC_LATCH_SET);
    wstat(8'h00, 1'b0);
    rd_status(8'h8E);
    set_wp(1'b1);
    wstat(8'h00, 1'b1);
    set_wp(1'b0);
    m.done_frame();
    rd_status(8'h8E);
    set_wp(1'b1);
    wstat(8'h04, 1'b0);
    repeat (WC + 10) @(posedge clk);
    rd_status(8'h04);
    $display("test protect done");
  endtask
  task automatic t_guard();
    cmd(OPC_LATCH_SET);
    awrite(10'h3FF, 8'h11);
    chk("wr_cnt", 16'h0000, 16'(wr_cnt));
    awrite(10'h2FF, 8'h5A);
    chk("wr_cnt", 16'h0001, 16'(wr_cnt));
    chk("wr_addr", 16'h02FF, 16'(wr_addr_seen));
    chk("wr_data", 16'h005A, 16'(wr_data_seen));
    repeat (WC + 10) @(posedge clk);
    $display("test guard done");
  endtask
  task automatic t_read_misc();
    m.xfer({OPC_ARRAY_READ, 6'h00, 10'h123, 8'h00}, 32, -1, 1'b0, rx, oe);
    chk("array_read", 16'h0086, 16'(rx[7:0]));
    m.xfer({8'hFF, OPC_STATUS_READ, 16'h0}, 32, -1, 1'b0, rx, oe);
    chk("bad_opc_oe", 16'h0000, 16'(oe));
    m.xfer({16'h0, OPC_STATUS_READ, 8'h00}, 16, 3, 1'b0, rx, oe);
    chk("hold_read", 16'h0004, 16'(rx[7:0]));
    chk("hold_oe", 16'h0000, 16'(m.hold_oe));
    $display("test read and pause done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_latch();
    t_status_write();
    t_protect();
    t_guard();
    t_read_misc();
    test_done();
  end
endmodule
